/* mif_consts.svh */
// Constants for the metering interrupt flag block: offsets, bit positions,
// reset values and masks.
// Assumes it is included by bare name after the package and before modules.
//
// Summary of operation
// [RULE_01] Every supported event sets its own bit in the event status word.
// [RULE_02] Interrupt request pin is pulled low while any enabled flag is set.
// [RULE_03] Host reads the status word first when servicing a request.
// [RULE_04] Bit 0 sets when active energy accumulator MSB rises, half full.
// [RULE_05] Bit 1 sets on a line voltage dip or missing zero crossings.
// [RULE_06] Bit 2 sets when half-line-cycle energy accumulation completes.
// [RULE_07] Bit 3 sets each time the waveform sample register is loaded.
// [RULE_08] Bit 4 follows the zero-crossing logic level, not latched.
// [RULE_09] Bit 5 sets when a temperature result becomes available.
// [RULE_10] Bit 6 sets after hardware or software reset; never raises interrupt.
// [RULE_11] Bit 7 sets when the active energy accumulator overflows.
// [RULE_12] Bit 8 sets when a voltage sample exceeds the voltage peak threshold.
// [RULE_13] Bit 9 sets when a current sample exceeds the current peak threshold.
// [RULE_14] Bit 10 sets when apparent energy accumulator MSB rises, half full.
// [RULE_15] Bit 11 sets when the apparent energy accumulator overflows.
// [RULE_16] Bit 12 sets when zero crossings are missing for programmed cycles.
// [RULE_17] Bit 13 sets when power changes from negative to positive.
// [RULE_18] Bit 14 sets when power goes positive to negative; bit 15 reserved.
// [RULE_19] Clear-on-read status returns flags, then clears all latched flags.
// [RULE_20] Interrupt pin floats once no set flag is enabled.
`ifndef MIF_CONSTS_SVH
`define MIF_CONSTS_SVH

// Register offsets
`define MIF_OFS_ENABLE 6'h0A
`define MIF_OFS_STATUS 6'h0C
`define MIF_OFS_STATUS_CLR 6'h0D
`define MIF_OFS_DIE_REV 6'h3F

// Status bit positions
`define MIF_BIT_AE_HALF 0
`define MIF_BIT_DIP 1
`define MIF_BIT_CYC 2
`define MIF_BIT_WAVE 3
`define MIF_BIT_ZERO 4
`define MIF_BIT_TEMP 5
`define MIF_BIT_RESET 6
`define MIF_BIT_AE_OVF 7
`define MIF_BIT_V_PEAK 8
`define MIF_BIT_I_PEAK 9
`define MIF_BIT_VAHF 10
`define MIF_BIT_VAOF 11
`define MIF_BIT_ZERO_TMO 12
`define MIF_BIT_POS 13
`define MIF_BIT_NEG 14

// Reset values and masks
`define MIF_ENABLE_RST 16'h0000
`define MIF_STATUS_RST 16'h0040
`define MIF_IRQ_ABLE 16'h7FBF
`define MIF_STATUS_USED 16'h7FFF

`endif

/* mif_pkg.sv */
// Types for the metering interrupt flag block.
// Assumes the event sources share the block clock.
package mif_pkg;

    // Event strobes and levels from the measurement datapath
    typedef struct packed {
        logic ae_msb;
        logic ae_overflow;
        logic va_msb;
        logic va_overflow;
        logic voltage_dip;
        logic no_zero_cross;
        logic cycle_done;
        logic sample_load;
        logic zero_cross;
        logic temp_done;
        logic zx_timeout;
        logic power_negative;
    } mif_events_t;

    // Waveform samples for peak detection
    typedef struct packed {
        logic v_valid;
        logic signed [23:0] v_sample;
        logic i_valid;
        logic signed [23:0] i_sample;
    } mif_wave_t;

    // Register access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [15:0] wdata;
    } mif_reg_req_t;

endpackage

/* mif_interrupt_flags.sv */
// Interrupt status, enable and request logic of the energy metering device.
// Assumes event inputs, thresholds and register requests come from logic on
// i_ref_clk; the serial port decodes frames into one-cycle rd/wr strobes.
`timescale 1ns/10ps
`default_nettype none

`include "mif_consts.svh"

module mif_interrupt_flags #(
    parameter logic [7:0] DIE_REVISION_CODE = 8'h11 // Arbitrary value
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sw_rst,
    input wire mif_pkg::mif_events_t i_events,
    input wire mif_pkg::mif_wave_t i_wave,
    input wire logic [23:0] i_voltage_peak_threshold,
    input wire logic [23:0] i_current_peak_threshold,
    input wire mif_pkg::mif_reg_req_t i_reg_req,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_irq_n_out,
    output logic o_irq_n_oe
);
    import mif_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic any_rst;
    logic [15:0] interrupt_enable_mask;
    logic [15:0] latched;
    logic [15:0] event_status_word;
    logic [15:0] set_vec;
    logic [15:0] next_rdata;
    logic ae_msb_d;
    logic va_msb_d;
    logic power_neg_d;
    logic edge_valid;
    logic v_peak_hit;
    logic i_peak_hit;
    logic clr_read;
    logic pending;

    // Either reset restarts the block the same way
    assign any_rst = i_rst | i_sw_rst;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection history

    // Previous levels; edge_valid blocks a false edge on the first cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
        begin
            ae_msb_d <= 1'b0;
            va_msb_d <= 1'b0;
            power_neg_d <= 1'b0;
            edge_valid <= 1'b0;
        end
        else
        begin
            ae_msb_d <= i_events.ae_msb;
            va_msb_d <= i_events.va_msb;
            power_neg_d <= i_events.power_negative;
            edge_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peak comparison

    // Two identical comparators, one per waveform channel
    mif_peak_compare u_v_peak (
        .i_valid(i_wave.v_valid),
        .i_sample(i_wave.v_sample),
        .i_threshold(i_voltage_peak_threshold),
        .o_hit(v_peak_hit) // see [RULE_12]
    );

    mif_peak_compare u_i_peak (
        .i_valid(i_wave.i_valid),
        .i_sample(i_wave.i_sample),
        .i_threshold(i_current_peak_threshold),
        .o_hit(i_peak_hit) // see [RULE_13]
    );

    ////////////////////////////////////////////////////////////////////////
    // Event set vector

    // One set term per latched flag; bits 4, 6 and 15 are not set here
    always_comb
    begin
        set_vec = 16'h0000;
        set_vec[`MIF_BIT_AE_HALF] = edge_valid & i_events.ae_msb & ~ae_msb_d; // see [RULE_04]
        set_vec[`MIF_BIT_DIP] = i_events.voltage_dip | i_events.no_zero_cross; // see [RULE_05]
        set_vec[`MIF_BIT_CYC] = i_events.cycle_done; // see [RULE_06]
        set_vec[`MIF_BIT_WAVE] = i_events.sample_load; // see [RULE_07]
        set_vec[`MIF_BIT_TEMP] = i_events.temp_done; // see [RULE_09]
        set_vec[`MIF_BIT_AE_OVF] = i_events.ae_overflow; // see [RULE_11]
        set_vec[`MIF_BIT_V_PEAK] = v_peak_hit; // see [RULE_12]
        set_vec[`MIF_BIT_I_PEAK] = i_peak_hit; // see [RULE_13]
        set_vec[`MIF_BIT_VAHF] = edge_valid & i_events.va_msb & ~va_msb_d; // see [RULE_14]
        set_vec[`MIF_BIT_VAOF] = i_events.va_overflow; // see [RULE_15]
        set_vec[`MIF_BIT_ZERO_TMO] = i_events.zx_timeout; // see [RULE_16]
        set_vec[`MIF_BIT_POS] = edge_valid & ~i_events.power_negative & power_neg_d; // see [RULE_17]
        set_vec[`MIF_BIT_NEG] = edge_valid & i_events.power_negative & ~power_neg_d; // see [RULE_18]
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access

    assign clr_read = i_reg_req.rd && (i_reg_req.addr == `MIF_OFS_STATUS_CLR);

    // Enable mask, written whole by the host
    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
            interrupt_enable_mask <= `MIF_ENABLE_RST;
        else if (i_reg_req.wr && (i_reg_req.addr == `MIF_OFS_ENABLE))
            interrupt_enable_mask <= i_reg_req.wdata;
    end

    // Sticky flags; a new event in the clearing cycle survives the clear
    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
            latched <= `MIF_STATUS_RST; // see [RULE_10]
        else if (clr_read)
            latched <= set_vec; // see [RULE_19]
        else
            latched <= latched | set_vec; // see [RULE_01]
    end

    // Bit 4 is a live copy of the zero-crossing level
    always_comb
    begin
        event_status_word = latched & `MIF_STATUS_USED;
        event_status_word[`MIF_BIT_ZERO] = i_events.zero_cross; // see [RULE_08]
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        unique case (i_reg_req.addr)
            `MIF_OFS_ENABLE: next_rdata = interrupt_enable_mask;
            `MIF_OFS_STATUS: next_rdata = event_status_word;
            `MIF_OFS_STATUS_CLR: next_rdata = event_status_word; // see [RULE_19]
            `MIF_OFS_DIE_REV: next_rdata = {8'h00, DIE_REVISION_CODE};
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
        begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_req.rd;
            if (i_reg_req.rd)
                o_reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request pin

    // Reset flag and reserved bit can never drive the request
    assign pending = |(event_status_word & interrupt_enable_mask & `MIF_IRQ_ABLE);

    // Open drain: pull low while pending, otherwise float
    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
            o_irq_n_oe <= 1'b0;
        else
            o_irq_n_oe <= pending; // see [RULE_02] [RULE_20]
    end

    // Driven level is always low; only the enable moves
    assign o_irq_n_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // A sample load then a plain cycle leaves bit 3 set
    sequence seq_wave_load;
        !clr_read && i_events.sample_load;
    endsequence

    sequence seq_quiet;
        !clr_read && !any_rst;
    endsequence

    AST_EVENT_STICKS: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_01]
        seq_wave_load ##1 seq_quiet |=> latched[`MIF_BIT_WAVE])
        else $error("status flag lost without a clear");

    AST_IRQ_FOLLOWS: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_02]
        pending |=> o_irq_n_oe && !o_irq_n_out)
        else $error("request not asserted for enabled flag");

    AST_AE_HALF: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_04]
        edge_valid && $rose(i_events.ae_msb) |=> latched[`MIF_BIT_AE_HALF])
        else $error("active energy half flag missed");

    AST_DIP: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_05]
        i_events.no_zero_cross || i_events.voltage_dip |=> latched[`MIF_BIT_DIP])
        else $error("dip flag missed");

    AST_ZERO_LIVE: assert property (@(posedge i_ref_clk) // see [RULE_08]
        event_status_word[`MIF_BIT_ZERO] == i_events.zero_cross)
        else $error("zero cross bit not live");

    AST_RESET_FLAG: assert property (@(posedge i_ref_clk) // see [RULE_10]
        $fell(any_rst) |-> latched[`MIF_BIT_RESET] && !o_irq_n_oe)
        else $error("reset flag missing or raised request");

    AST_RESET_NO_IRQ: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_10]
        event_status_word == 16'h0040 |=> !o_irq_n_oe)
        else $error("reset flag drove the request");

    AST_PEAK_V: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_12]
        i_wave.v_valid && !i_wave.v_sample[23]
        && (24'(i_wave.v_sample) > i_voltage_peak_threshold) |=> latched[`MIF_BIT_V_PEAK])
        else $error("voltage peak flag missed");

    AST_SIGN_POS: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_17]
        edge_valid && $fell(i_events.power_negative) |=> latched[`MIF_BIT_POS])
        else $error("positive going flag missed");

    AST_SIGN_NEG: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_18]
        edge_valid && $rose(i_events.power_negative) |=> latched[`MIF_BIT_NEG]
        && !event_status_word[15])
        else $error("negative going flag missed");

    AST_CLEAR_READ: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_19]
        clr_read && set_vec == 16'h0000 |=> latched == 16'h0000
        && o_reg_rdata == $past(event_status_word))
        else $error("clear on read failed");

    AST_IRQ_RELEASE: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_20]
        !pending |=> !o_irq_n_oe)
        else $error("request held with nothing enabled");

    // Pulse sources: the flag is up one cycle after the strobe, clearing read or not
    AST_CYCLE_DONE: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_06]
        i_events.cycle_done |=> latched[`MIF_BIT_CYC])
        else $error("line cycle flag missed");

    AST_WAVE_LOAD: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_07]
        i_events.sample_load |=> latched[`MIF_BIT_WAVE])
        else $error("sample flag missed");

    AST_TEMP_DONE: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_09]
        i_events.temp_done |=> latched[`MIF_BIT_TEMP])
        else $error("temperature flag missed");

    AST_AE_OVF: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_11]
        i_events.ae_overflow |=> latched[`MIF_BIT_AE_OVF])
        else $error("active energy overflow flag missed");

    AST_PEAK_I: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_13]
        i_wave.i_valid && !i_wave.i_sample[23]
        && (24'(i_wave.i_sample) > i_current_peak_threshold) |=> latched[`MIF_BIT_I_PEAK])
        else $error("current peak flag missed");

    AST_VA_HALF: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_14]
        edge_valid && $rose(i_events.va_msb) |=> latched[`MIF_BIT_VAHF])
        else $error("apparent energy half flag missed");

    AST_VA_OVF: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_15]
        i_events.va_overflow |=> latched[`MIF_BIT_VAOF])
        else $error("apparent energy overflow flag missed");

    AST_ZERO_TMO: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_16]
        i_events.zx_timeout |=> latched[`MIF_BIT_ZERO_TMO])
        else $error("zero crossing timeout flag missed");

    // Register side: plain status reads answer next cycle, writes land whole
    AST_STATUS_READ: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_01]
        i_reg_req.rd && i_reg_req.addr == `MIF_OFS_STATUS
        |=> o_reg_rvalid && o_reg_rdata == $past(event_status_word))
        else $error("status read returned stale data");

    AST_READ_IDLE: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_19]
        !i_reg_req.rd |=> !o_reg_rvalid)
        else $error("read answer without a read");

    AST_ENABLE_WRITE: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_02]
        i_reg_req.wr && i_reg_req.addr == `MIF_OFS_ENABLE
        |=> interrupt_enable_mask == $past(i_reg_req.wdata))
        else $error("enable mask write lost");

    AST_RESERVED_ZERO: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_18]
        event_status_word[15] == 1'b0)
        else $error("reserved status bit set");

    // Clearing read with nothing new and the live bit low: the pin lets go
    sequence seq_clear_all;
        clr_read && set_vec == 16'h0000 && !i_events.zero_cross;
    endsequence

    sequence seq_still;
        !any_rst && !i_events.zero_cross;
    endsequence

    AST_CLEAR_FREES: assert property (@(posedge i_ref_clk) disable iff (any_rst) // see [RULE_20]
        seq_clear_all ##1 seq_still |=> !o_irq_n_oe)
        else $error("request held after clearing read");

endmodule

////////////////////////////////////////////////////////////////////////////
// Peak comparator, one per waveform channel

module mif_peak_compare (
    input wire logic i_valid,
    input wire logic signed [23:0] i_sample,
    input wire logic [23:0] i_threshold,
    output logic o_hit
);
    import mif_pkg::*;

    logic [23:0] mag;

    // Most negative code saturates; plain negation would wrap it to itself
    always_comb
    begin
        if (i_sample == 24'sh800000)
            mag = 24'h7FFFFF;
        else if (i_sample[23])
            mag = 24'(-i_sample);
        else
            mag = 24'(i_sample);
    end

    // Strict compare: a sample equal to the threshold is not a peak
    assign o_hit = i_valid && (mag > i_threshold);
endmodule

`default_nettype wire

/* mif_host_model.sv */
// Host model: register reads and writes, interrupt servicing.
// Assumes the bench resolves the open-drain request pin with a pull-up.
`timescale 1ns/10ps
`default_nettype none

`include "mif_consts.svh"

module mif_host_model (
    input wire logic i_ref_clk,
    input wire logic i_irq_n,
    input wire logic [15:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output var mif_pkg::mif_reg_req_t o_reg_req
);
    import mif_pkg::*;

    initial o_reg_req = '{rd: 1'b0, wr: 1'b0, addr: 6'h15, wdata: 16'h5A5A};

    ////////////////////////////////////////////////////////////////////////
    // One access; released lines go inverse so stale values never help
    task automatic access(input logic rd, input logic [5:0] addr,
                          input logic [15:0] wdata, output logic [15:0] data);
        @(posedge i_ref_clk);
        #1;
        o_reg_req = '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
        @(posedge i_ref_clk);
        #1;
        o_reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        data = i_reg_rvalid ? i_reg_rdata : 16'hXXXX; // Missing answer never matches
    endtask

    task automatic rd(input logic [5:0] addr, output logic [15:0] data);
        access(1'b1, addr, 16'h0000, data);
    endtask

    task automatic wr(input logic [5:0] addr, input logic [15:0] wdata);
        logic [15:0] dummy;
        access(1'b0, addr, wdata, dummy);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Wait for the request, dawdle a little, then read status first
    task automatic service(input int lag, output logic [15:0] status, output logic seen);
        int n;
        n = 0;
        while (i_irq_n !== 1'b0 && n < 20)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        seen = (i_irq_n === 1'b0);
        repeat (lag) @(posedge i_ref_clk);
        rd(`MIF_OFS_STATUS_CLR, status);
    endtask
endmodule

`default_nettype wire

/* test_metering_interrupt_flags.sv */
// Self-checking bench for the interrupt flag block.
// Assumes the host model drives the register port and a pull-up on the pin.
`timescale 1ns/10ps
`default_nettype none

`include "mif_consts.svh"

module test_metering_interrupt_flags;
    import mif_pkg::*;

    localparam logic [7:0] REV = 8'h5A; // Arbitrary value
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_sw_rst = 1'b0;
    logic [11:0] ev = 12'h000;
    mif_wave_t wave = '0;
    logic [23:0] vthr = 24'h000000;
    logic [23:0] ithr = 24'h000000;
    mif_reg_req_t req;
    logic [15:0] rdata, got, en;
    logic rvalid, irq_out, irq_oe, irq_n, ok, hit;
    logic signed [23:0] s1, s2;
    logic [31:0] seed = 32'hC435;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int j;
    // Event vector index and the status bits it must raise
    int ev_idx [11] = '{10, 8, 7, 6, 5, 4, 2, 1, 11, 9, 0};
    logic [15:0] ev_mask [11] = '{16'h0080,
        16'h0800,
        16'h0002,
        16'h0002,
        16'h0004,
        16'h0008,
        16'h0020,
        16'h1000,
        16'h0001,
        16'h0400,
        16'h6000};

    always #5 i_ref_clk = ~i_ref_clk;
    assign irq_n = irq_oe ? irq_out : 1'b1; // Pull-up on the open-drain pin

    mif_interrupt_flags #(.DIE_REVISION_CODE(REV)) dut (.i_ref_clk(i_ref_clk),
        .i_rst(i_rst), .i_sw_rst(i_sw_rst), .i_events(mif_events_t'(ev)), .i_wave(wave),
        .i_voltage_peak_threshold(vthr), .i_current_peak_threshold(ithr),
        .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .o_irq_n_out(irq_out), .o_irq_n_oe(irq_oe));

    mif_host_model host (.i_ref_clk(i_ref_clk), .i_irq_n(irq_n),
        .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_req(req));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Strict magnitude compare, most negative sample saturates
    function automatic logic peak_hit(input logic signed [23:0] s, input logic [23:0] thr);
        logic [23:0] mag;
        mag = s[23] ? -s : s;
        if (s == 24'sh800000)
            mag = 24'h7FFFFF;
        return mag > thr;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(6);
        i_rst = 1'b0;
        host.rd(`MIF_OFS_STATUS, got);
        check(got, 16'h0040);
        host.rd(`MIF_OFS_STATUS, got);
        check(got, 16'h0040);
        host.rd(`MIF_OFS_ENABLE, got);
        check(got, 16'h0000);
        host.rd(`MIF_OFS_DIE_REV, got);
        check(got, {8'h00, REV});
        host.rd(6'h01, got);
        check(got, 16'h0000);
        host.rd(`MIF_OFS_STATUS_CLR, got);
        check(got, 16'h0040);
        host.rd(`MIF_OFS_STATUS, got);
        check(got, 16'h0000);
        $display("test reset_values done");
        // Software reset restores defaults; reset flag never drives the pin
        host.wr(`MIF_OFS_ENABLE, 16'hFFFF);
        i_sw_rst = 1'b1;
        tick(1);
        i_sw_rst = 1'b0;
        host.rd(`MIF_OFS_ENABLE, got);
        check(got, 16'h0000);
        host.wr(`MIF_OFS_ENABLE, 16'hFFFF);
        tick(3);
        check({15'h0000, irq_n}, 16'h0001);
        host.rd(`MIF_OFS_STATUS_CLR, got);
        check(got, 16'h0040);
        $display("test software_reset done");
        // Every latched event of the event vector, first fully enabled, then under random masks
        for (int k = 0; k < 22; k++)
        begin
            j = k % 11;
            en = (k < 11) ? 16'h7FBF : seed[15:0];
            host.wr(`MIF_OFS_ENABLE, en);
            ev[ev_idx[j]] = 1'b1;
            tick(1);
            ev[ev_idx[j]] = 1'b0;
            tick(3);
            hit = (ev_mask[j] & en & 16'h7FBF) != 16'h0000;
            check({15'h0000, irq_n}, {15'h0000, !hit});
            if (hit)
            begin
                host.service(int'(seed[1:0]), got, ok);
                check({15'h0000, ok}, 16'h0001);
            end
            else
                host.rd(`MIF_OFS_STATUS_CLR, got);
            check(got, ev_mask[j]);
            tick(1);
            check({15'h0000, irq_n}, 16'h0001);
            seed = next_rand(seed);
        end
        $display("test event_flags done");
        // Zero-cross bit follows the live level
        ev[3] = 1'b1;
        tick(2);
        host.rd(`MIF_OFS_STATUS_CLR, got);
        check(got, 16'h0010);
        ev[3] = 1'b0;
        tick(2);
        host.rd(`MIF_OFS_STATUS, got);
        check(got, 16'h0000);
        $display("test zero_cross done");
        // Peak detection, equal and saturated corners first
        for (int k = 0; k < 10; k++)
        begin
            seed = next_rand(seed);
            vthr = {2'b00, seed[21:0]};
            s1 = seed[31:8];
            seed = next_rand(seed);
            ithr = {2'b00, seed[21:0]};
            s2 = seed[31:8];
            if (k == 0)
            begin
                s1 = vthr;
                s2 = 24'sh800000;
                ithr = 24'h7FFFFE;
            end
            wave = '{v_valid: 1'b1, v_sample: s1, i_valid: 1'b1, i_sample: s2};
            tick(1);
            wave.v_valid = 1'b0;
            wave.i_valid = 1'b0;
            tick(2);
            host.rd(`MIF_OFS_STATUS_CLR, got);
            check(got, {6'h00, peak_hit(s2, ithr), peak_hit(s1, vthr),
                8'h00});
        end
        $display("test peak_levels done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
